// File: hdl/ulsf_line_status.v
/*
 Line status bits 7..3 of one UART channel, with the receive FIFO
 error tags that feed them. Holds a tag per receive FIFO slot,
 tracks holding/shift occupancy and raises the holding-empty
 interrupt request. Assumes the receiver, transmit FIFO and host bus
 logic of the channel run on sys_clk; only rx_pin is asynchronous.
*/
// Function
// - Bit 7 is one while any character still in the receive FIFO carries an error tag.
// - Bit 7 clears only once no remaining character carries an error tag.
// - Outside FIFO mode bit 6 is one when holding and shift registers are both empty.
// - Bit 6 is zero whenever the holding or shift register holds a character.
// - In FIFO mode bit 6 is one only when transmit FIFO and shift register are empty.
// - Outside FIFO mode bit 5 sets when a character moves from holding to shift register.
// - Outside FIFO mode bit 5 clears in the cycle the host writes the holding register.
// - Bit 5 high with its interrupt enable set requests an interrupt.
// - In FIFO mode bit 5 sets when the transmit FIFO empties and clears on a write to it.
// - Bit 4 sets when the receive line stayed low for a whole character frame.
// - In FIFO mode a continuous break loads only one break character.
// - Bit 3 sets when a received character lacks a valid stop bit.
// - In FIFO mode bit 3 reflects the character at the head of the receive FIFO.
// - After reset bits 7, 4 and 3 stay zero until a qualifying receive event.
`timescale 1ns/1ps
`include "ulsf_regs.vh"
module ulsf_line_status (
  input wire sys_clk,
  input wire resetn,
  input wire fifo_mode,
  input wire rx_pin,
  input wire bit_tick,
  input wire [3:0] frame_bits,
  input wire rx_push,
  input wire rx_push_parity_err,
  input wire rx_push_frame_err,
  input wire rx_pop,
  input wire rx_flush,
  input wire host_tx_write,
  input wire tx_load_shift,
  input wire tx_shift_busy,
  input wire tx_fifo_empty,
  input wire ls_read,
  input wire hold_empty_int_en,
  output reg [7:0] line_status,
  output reg hold_empty_int_req,
  output reg break_char_push
);
  reg rx_meta;
  reg rx_sync;
  reg [`ULSF_TAG_W-1:0] tag_mem [0:`ULSF_FIFO_DEPTH-1];
  reg [`ULSF_FIFO_AW-1:0] wr_ptr;
  reg [`ULSF_FIFO_AW-1:0] rd_ptr;
  reg [`ULSF_CNT_W-1:0] rx_count;
  reg [`ULSF_CNT_W-1:0] err_count;
  reg hold_full;
  reg hold_empty;
  reg brk_sticky;
  reg frm_sticky;
  wire break_push;
  wire push_any;
  wire do_push;
  wire do_pop;
  wire [`ULSF_TAG_W-1:0] push_tag;
  wire [`ULSF_TAG_W-1:0] head_tag;
  wire tx_empty_now;
  wire hold_empty_now;
  wire [7:0] next_line_status;
  reg [`ULSF_CNT_W-1:0] next_err_count;
  wire [`ULSF_FIFO_AW-1:0] next_rd_ptr;
  wire [`ULSF_CNT_W-1:0] next_rx_count;
  wire [`ULSF_TAG_W-1:0] next_head_tag;
  integer i;

  // True when a tag carries any error that counts toward bit 7
  function tag_has_err;
    input [`ULSF_TAG_W-1:0] t;
    begin
      tag_has_err = |t;
    end
  endfunction

  // Two-stage synchroniser on the serial input
  always @(posedge sys_clk) begin
    if (!resetn) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= rx_pin;
      rx_sync <= rx_meta;
    end
  end

  ulsf_rx_break u_break (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .bit_tick(bit_tick),
    .rx_sync(rx_sync),
    .frame_bits(frame_bits),
    .break_push(break_push)
  );

  // A break character takes the slot a normal character would; if both
  // land in one cycle the break wins since the frame was all zeros
  assign push_any = rx_push | break_push;
  assign push_tag = break_push ? 3'h4 : {1'b0, rx_push_frame_err, rx_push_parity_err};
  assign do_push = push_any && (rx_count != 8'h80 || rx_pop);
  assign do_pop = rx_pop && (rx_count != 8'h00);
  assign head_tag = tag_mem[rd_ptr];
  // Head and fill after this edge, so status shows the event one cycle on
  assign next_rd_ptr = rx_flush ? 7'h00 : (do_pop ? rd_ptr + 7'h01 : rd_ptr);
  assign next_rx_count = rx_flush ? 8'h00 :
                         (do_push && !do_pop) ? rx_count + 8'h01 :
                         (do_pop && !do_push) ? rx_count - 8'h01 : rx_count;
  // A slot written in this cycle that becomes the head is bypassed
  assign next_head_tag = (do_push && !rx_flush && next_rd_ptr == wr_ptr) ? push_tag
                                                                          : tag_mem[next_rd_ptr];

  // Tag store beside the receive FIFO, same pointers as the data side
  always @(posedge sys_clk) begin
    if (!resetn) begin
      for (i = 0; i < `ULSF_FIFO_DEPTH; i = i + 1) begin
        tag_mem[i] <= 3'h0;
      end
      wr_ptr <= 7'h00;
      rd_ptr <= 7'h00;
      rx_count <= 8'h00;
    end else if (rx_flush) begin
      wr_ptr <= 7'h00;
      rd_ptr <= 7'h00;
      rx_count <= 8'h00;
    end else begin
      if (do_push) begin
        tag_mem[wr_ptr] <= push_tag;
        wr_ptr <= wr_ptr + 7'h01;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 7'h01;
      end
      if (do_push && !do_pop) begin
        rx_count <= rx_count + 8'h01;
      end else if (do_pop && !do_push) begin
        rx_count <= rx_count - 8'h01;
      end
    end
  end

  // Count of tagged entries still in the FIFO drives the summary bit
  always @* begin
    next_err_count = err_count;
    if (rx_flush) begin
      next_err_count = 8'h00;
    end else begin
      case ({do_push && tag_has_err(push_tag), do_pop && tag_has_err(head_tag)})
        2'b10: next_err_count = err_count + 8'h01;
        2'b01: next_err_count = err_count - 8'h01;
        default: next_err_count = err_count;
      endcase
    end
  end

  // Registered count; the status bit reads the next value
  always @(posedge sys_clk) begin
    if (!resetn) begin
      err_count <= 8'h00;
    end else begin
      err_count <= next_err_count;
    end
  end

  // Non-FIFO mode keeps sticky break/framing flags, cleared by a status
  // read; a new event in the read cycle wins over the clear
  always @(posedge sys_clk) begin
    if (!resetn) begin
      brk_sticky <= 1'b0;
      frm_sticky <= 1'b0;
    end else begin
      brk_sticky <= break_push | (brk_sticky & ~ls_read);
      frm_sticky <= (rx_push & rx_push_frame_err) | (frm_sticky & ~ls_read);
    end
  end

  // Holding register occupancy outside FIFO mode
  always @(posedge sys_clk) begin
    if (!resetn) begin
      hold_full <= 1'b0;
      hold_empty <= 1'b1;
    end else if (host_tx_write) begin
      hold_full <= 1'b1;
      hold_empty <= 1'b0;
    end else if (tx_load_shift) begin
      hold_full <= 1'b0;
      hold_empty <= 1'b1;
    end
  end

  // Transmitter empty: both stages idle, in either mode
  assign tx_empty_now = fifo_mode ? (tx_fifo_empty && !tx_shift_busy)
                                  : ((!hold_full || tx_load_shift) && !host_tx_write
                                     && !tx_shift_busy);
  // In FIFO mode the FIFO's own empty flag drops on the write cycle
  assign hold_empty_now = fifo_mode ? (tx_fifo_empty && !host_tx_write)
                                    : ((hold_empty || tx_load_shift) && !host_tx_write);

  assign next_line_status = {
    next_err_count != 8'h00,
    tx_empty_now,
    hold_empty_now,
    fifo_mode ? next_head_tag[`ULSF_TAG_BRK] && next_rx_count != 8'h00
              : (break_push | brk_sticky),
    fifo_mode ? next_head_tag[`ULSF_TAG_FRM] && next_rx_count != 8'h00
              : ((rx_push & rx_push_frame_err) | frm_sticky),
    3'h0
  };

  // Registered status and interrupt request; outputs come from flops
  always @(posedge sys_clk) begin
    if (!resetn) begin
      line_status <= `ULSF_LS_RESET;
      hold_empty_int_req <= 1'b0;
      break_char_push <= 1'b0;
    end else begin
      line_status <= next_line_status;
      hold_empty_int_req <= next_line_status[`ULSF_LS_HOLD_EMPTY] & hold_empty_int_en;
      break_char_push <= break_push & fifo_mode;
    end
  end
endmodule // ulsf_line_status

// File: hdl/ulsf_rx_break.v
/*
 Break detector for the receive line. Counts bit periods the
 synchronised receive line stays low; flags a break once a whole
 frame (start, data, parity, stop) has passed low, and emits one
 break push per continuous break. Assumes rx_sync is already
 synchronised and bit_tick is a one-cycle pulse per 16x sample.
*/
`timescale 1ns/1ps
`include "ulsf_regs.vh"
module ulsf_rx_break (
  input wire sys_clk,
  input wire resetn,
  input wire bit_tick,
  input wire rx_sync,
  input wire [3:0] frame_bits,
  output reg break_push
);
  reg [`ULSF_OVS_W-1:0] ovs_cnt;
  reg [`ULSF_BITS_W:0] low_bits;
  reg in_break;

  // Count whole bit periods of low line; one push per break
  always @(posedge sys_clk) begin
    if (!resetn) begin
      ovs_cnt <= 4'h0;
      low_bits <= 5'h00;
      in_break <= 1'b0;
      break_push <= 1'b0;
    end else begin
      break_push <= 1'b0;
      if (rx_sync) begin
        // Line released: rearm for the next break
        ovs_cnt <= 4'h0;
        low_bits <= 5'h00;
        in_break <= 1'b0;
      end else if (bit_tick && !in_break) begin
        ovs_cnt <= ovs_cnt + 4'h1;
        if (ovs_cnt == 4'hF) begin
          if (low_bits + 5'h01 >= {1'b0, frame_bits}) begin
            in_break <= 1'b1;
            break_push <= 1'b1;
          end else begin
            low_bits <= low_bits + 5'h01;
          end
        end
      end
    end
  end
endmodule // ulsf_rx_break

// File: inc/ulsf_regs.vh
/*
 Constants for the line status flag block: bit positions of the
 line_status register, reset value and receive frame sizing.
 Assumes plain Verilog-2005 inclusion by bare name.
*/
`ifndef ULSF_REGS_VH
`define ULSF_REGS_VH
`define ULSF_LS_FIFO_ERR 7
`define ULSF_LS_TX_EMPTY 6
`define ULSF_LS_HOLD_EMPTY 5
`define ULSF_LS_BREAK 4
`define ULSF_LS_FRAME_ERR 3
`define ULSF_LS_RESET 8'h60
`define ULSF_FIFO_DEPTH 128
`define ULSF_FIFO_AW 7
`define ULSF_CNT_W 8
`define ULSF_TAG_W 3
`define ULSF_TAG_PAR 0
`define ULSF_TAG_FRM 1
`define ULSF_TAG_BRK 2
`define ULSF_OVS 16
`define ULSF_OVS_W 4
`define ULSF_BITS_W 4
`endif

// File: tb/uart_line_status_flags_tb.sv
/*
 Self-checking bench for the line status flags with host model.
 Assumes a 50 MHz clock and bit_tick held high to keep breaks short.
*/
`timescale 1ns/1ps
module uart_line_status_flags_tb;
  reg sys_clk = 1'b0;
  reg resetn = 1'b0;
  reg fifo_mode = 1'b0, rx_pin = 1'b1, bit_tick = 1'b1, rx_push = 1'b0;
  reg rx_push_parity_err = 1'b0, rx_push_frame_err = 1'b0, rx_flush = 1'b0;
  reg tx_load_shift = 1'b0, tx_shift_busy = 1'b0, tx_fifo_empty = 1'b1;
  reg hold_empty_int_en = 1'b1;
  reg [3:0] frame_bits = 4'hA;
  wire host_tx_write, ls_read, rx_pop, hold_empty_int_req, break_char_push;
  wire [7:0] line_status;
  integer err_count = 0, checked = 0, cycles = 0, brk = 0;
  ulsf_line_status ulsf_line_status_i (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .fifo_mode(fifo_mode),
    .rx_pin(rx_pin),
    .bit_tick(bit_tick),
    .frame_bits(frame_bits),
    .rx_push(rx_push),
    .rx_push_parity_err(rx_push_parity_err),
    .rx_push_frame_err(rx_push_frame_err),
    .rx_pop(rx_pop),
    .rx_flush(rx_flush),
    .host_tx_write(host_tx_write),
    .tx_load_shift(tx_load_shift),
    .tx_shift_busy(tx_shift_busy),
    .tx_fifo_empty(tx_fifo_empty),
    .ls_read(ls_read),
    .hold_empty_int_en(hold_empty_int_en),
    .line_status(line_status),
    .hold_empty_int_req(hold_empty_int_req),
    .break_char_push(break_char_push)
  );
  ulsf_host ulsf_host_i (
    .sys_clk(sys_clk),
    .host_tx_write(host_tx_write),
    .ls_read(ls_read),
    .rx_pop(rx_pop)
  );
  always #10 sys_clk = ~sys_clk;
  // Cycle ceiling, and a tally of break pushes
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    brk <= brk + break_char_push;
    if (cycles == 3000) begin
      err_count = err_count + 1;
      print_verdict;
    end
  end
  task check(input [7:0] seen, input [7:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task step(input integer n);
    begin
      repeat (n) @(posedge sys_clk);
      #1;
    end
  endtask
  // One received character; its tag rides with the push
  task push(input fe);
    begin
      rx_push = 1'b1;
      rx_push_frame_err = fe;
      step(1);
      rx_push = 1'b0;
      rx_push_frame_err = 1'b0;
    end
  endtask
  task print_verdict;
    begin
      $display("checked=%0d err_count=%0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    step(2);
    check(line_status, 8'h60);
    resetn = 1'b1;
    tx_shift_busy = 1'b1;
    ulsf_host_i.strobe(0);
    check(line_status & 8'h60, 8'h00);
    tx_load_shift = 1'b1;
    step(1);
    tx_load_shift = 1'b0;
    check(line_status & 8'h60, 8'h20);
    step(1);
    check({7'h00, hold_empty_int_req}, 8'h01);
    tx_shift_busy = 1'b0;
    hold_empty_int_en = 1'b0;
    step(2);
    check(line_status & 8'h60, 8'h60);
    check({7'h00, hold_empty_int_req}, 8'h00);
    hold_empty_int_en = 1'b1;
    push(1'b1);
    check(line_status & 8'h08, 8'h08);
    ulsf_host_i.strobe(1);
    step(1);
    check(line_status & 8'h08, 8'h00);
    rx_flush = 1'b1;
    step(1);
    rx_flush = 1'b0;
    check(line_status & 8'h80, 8'h00);
    // Clean head with a bad character behind it
    fifo_mode = 1'b1;
    push(1'b0);
    push(1'b1);
    check(line_status & 8'h88, 8'h80);
    ulsf_host_i.strobe(2);
    check(line_status & 8'h88, 8'h88);
    ulsf_host_i.strobe(2);
    check(line_status & 8'h88, 8'h00);
    tx_fifo_empty = 1'b0;
    ulsf_host_i.strobe(0);
    check(line_status & 8'h60, 8'h00);
    tx_fifo_empty = 1'b1;
    step(2);
    check(line_status & 8'h60, 8'h60);
    // Line held low well past one frame must load one break only
    rx_pin = 1'b0;
    step(400);
    check(line_status & 8'h90, 8'h90);
    check(brk[7:0], 8'h01);
    rx_pin = 1'b1;
    step(20);
    print_verdict;
  end
endmodule // uart_line_status_flags_tb
bind ulsf_line_status ulsf_monitor ulsf_monitor_i (
  .sys_clk(sys_clk),
  .resetn(resetn),
  .fifo_mode(fifo_mode),
  .rx_push(rx_push),
  .rx_push_frame_err(rx_push_frame_err),
  .rx_pop(rx_pop),
  .rx_flush(rx_flush),
  .host_tx_write(host_tx_write),
  .tx_load_shift(tx_load_shift),
  .tx_shift_busy(tx_shift_busy),
  .hold_empty_int_en(hold_empty_int_en),
  .line_status(line_status),
  .hold_empty_int_req(hold_empty_int_req),
  .break_char_push(break_char_push)
);

// File: tb/ulsf_host.sv
/*
 Host model: one-cycle strobes for transmit write, status read, pop.
 Assumes it is called just after a rising edge of sys_clk.
*/
`timescale 1ns/1ps
module ulsf_host (
  input wire sys_clk,
  output reg host_tx_write,
  output reg ls_read,
  output reg rx_pop
);
  initial {host_tx_write, ls_read, rx_pop} = 3'h0;
  // Kind 0 writes, 1 reads status, 2 pops; held over one sampling edge
  task strobe(input integer k);
    begin
      host_tx_write = (k == 0);
      ls_read = (k == 1);
      rx_pop = (k == 2);
      @(posedge sys_clk);
      #1 {host_tx_write, ls_read, rx_pop} = 3'h0;
    end
  endtask
endmodule // ulsf_host

// File: tb/ulsf_monitor.sv
/*
 Checker for the line status flag block, bound to its top module.
 Assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module ulsf_monitor (
  input wire sys_clk,
  input wire resetn,
  input wire fifo_mode,
  input wire rx_push,
  input wire rx_push_frame_err,
  input wire rx_pop,
  input wire rx_flush,
  input wire host_tx_write,
  input wire tx_load_shift,
  input wire tx_shift_busy,
  input wire hold_empty_int_en,
  input wire [7:0] line_status,
  input wire hold_empty_int_req,
  input wire break_char_push
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Tagged character entering the receive queue, no pop racing it
  sequence s_bad_push;
    fifo_mode && rx_push && rx_push_frame_err && !rx_flush && !rx_pop;
  endsequence
  // Host write outside queue mode with no transfer in the same cycle
  sequence s_write;
    !fifo_mode && host_tx_write && !tx_load_shift;
  endsequence
  rst_value_a: assert property (disable iff (1'b0) !resetn |=> line_status == 8'h60)
    else $error("reset value wrong");
  err_sum_a: assert property (s_bad_push |=> line_status[7])
    else $error("error summary not set");
  flush_clear_a: assert property (rx_flush && !rx_push |=> !line_status[7])
    else $error("error summary not cleared");
  hold_clear_a: assert property (s_write |=> !line_status[5] && !line_status[6])
    else $error("holding flags not cleared");
  hold_set_a: assert property (!fifo_mode && tx_load_shift && !host_tx_write |=> line_status[5])
    else $error("holding empty not set");
  busy_empty_a: assert property (tx_shift_busy |=> !line_status[6])
    else $error("transmit empty while shifting");
  int_req_a: assert property ($past(resetn) |-> hold_empty_int_req == (line_status[5] && $past(hold_empty_int_en)))
    else $error("interrupt request missing");
  brk_once_a: assert property (break_char_push |=> !break_char_push)
    else $error("break push longer than one cycle");
endmodule // ulsf_monitor
